/* File: logic/smr_mode_decode.sv */
// decoder from requested mode to active mode indications
`timescale 1ns/1ps
module smr_mode_decode
    import smr_pkg::*;
(
    smr_mode_if.dec m
);

    // ----------------------------------------------------------------
    // mode decode
    // ----------------------------------------------------------------
    always_comb
    begin
        m.active_mode     = ACT_MANUAL;
        m.manual_ch0_only = 1'b0;
        m.auto_sequence   = 1'b0;
        m.mode_reserved   = 1'b0;
        case (m.requested_mode)
            3'b000, 3'b001:
            begin
                m.manual_ch0_only = 1'b1;
            end
            3'b010, 3'b011:
            begin
                m.mode_reserved = 1'b1;
            end
            3'b100, 3'b101:
            begin
                m.auto_sequence = 1'b1;
            end
            3'b110:
            begin
                m.active_mode   = ACT_AUTONOMOUS;
                m.auto_sequence = 1'b1;
            end
            3'b111:
            begin
                m.active_mode   = ACT_PRECISION;
                m.auto_sequence = 1'b1;
            end
            default:
            begin
                m.mode_reserved = 1'b1;
            end
        endcase
    end

endmodule : smr_mode_decode

/* File: logic/smr_mode_if.sv */
// carrier for decoded mode between the bank and its decoder
`timescale 1ns/1ps
interface smr_mode_if;
    logic [2:0] requested_mode;
    logic [1:0] active_mode;
    logic       manual_ch0_only;
    logic       auto_sequence;
    logic       mode_reserved;
    modport bank (output requested_mode, input active_mode, manual_ch0_only, auto_sequence, mode_reserved);
    modport dec  (input requested_mode, output active_mode, manual_ch0_only, auto_sequence, mode_reserved);
endinterface : smr_mode_if

/* File: logic/smr_pkg.sv */
// constants and types for the sensor monitor mode and reset register bank
package smr_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_MODE_AND_BUS_STATUS    = 8'h00;
    localparam logic [7:0] ADDR_SOFT_RESET_TRIGGER     = 8'h14;
    localparam logic [7:0] ADDR_CALIBRATION_TRIGGER    = 8'h15;
    localparam logic [7:0] ADDR_RESET_UNLOCK_KEY       = 8'h17;
    localparam logic [7:0] ADDR_OPERATING_MODE_SELECT  = 8'h1C;
    localparam logic [7:0] ADDR_INPUT_PIN_CONFIG       = 8'h24;

    // ----------------------------------------------------------------
    // fields and reset values
    // ----------------------------------------------------------------
    localparam logic [3:0] UNLOCK_PATTERN_VALUE = 4'hA;
    localparam logic [3:0] UNLOCK_PATTERN_RST   = 4'h0;
    localparam logic [2:0] REQUESTED_MODE_RST   = 3'h0;
    localparam logic [1:0] INPUT_ARRANGEMENT_RST = 2'h0;
    localparam int         SOFT_RESET_BIT_POS   = 0;
    localparam int         START_CAL_BIT_POS    = 0;
    localparam int         FAST_BUS_ACTIVE_POS  = 2;
    localparam logic [7:0] READ_ZERO            = 8'h00;

    // ----------------------------------------------------------------
    // modes
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ACT_MANUAL      = 2'b00,
        ACT_UNUSED      = 2'b01,
        ACT_AUTONOMOUS  = 2'b10,
        ACT_PRECISION   = 2'b11
    } smr_active_mode_type;

    typedef enum logic [1:0] {
        CFG_TWO_SINGLE   = 2'b00,
        CFG_REMOTE_GND   = 2'b01,
        CFG_PSEUDO_DIFF  = 2'b10,
        CFG_TWO_SINGLE_B = 2'b11
    } smr_input_cfg_type;

endpackage : smr_pkg

/* File: logic/smr_regs.sv */
// mode, calibration, input configuration and keyed reset register bank
//
// What this block does
// - four-bit unlock pattern in key bits 3-0; 1010b permits reset writes
// - soft reset register writes honoured only while key holds 1010b
// - key register survives a device reset
// - key bits 7-4 read zero; host must not write them
// - writing 1 to reset bit 0 when unlocked resets the device
// - writing 1 to calibration bit 0 starts offset calibration unless a device or general-call reset is active
// - three-bit mode select decodes manual, sequencing, autonomous, precision, reserved
// - status bit 2 shows bus high-speed operation, read only
// - two-bit active mode status: 00 manual, 10 autonomous, 11 precision
// - two-bit input arrangement selects single-ended, remote ground or pseudo-differential
// - mode select bits 7-3 always read zero
// - registers return to defaults on power-up and general-call reset
`timescale 1ns/1ps
module smr_regs
    import smr_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    input  wire logic       gen_call_reset_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic [7:0]      reg_rdata_o,
    input  wire logic       fast_bus_active_i,
    output logic            device_reset_o,
    output logic            start_calibration_o,
    output logic [2:0]      requested_mode_o,
    output logic [1:0]      active_mode_o,
    output logic            manual_ch0_only_o,
    output logic            auto_sequence_o,
    output logic            mode_reserved_o,
    output logic [1:0]      input_arrangement_o,
    output logic            two_single_ended_o,
    output logic            remote_ground_sense_o,
    output logic            pseudo_differential_o
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [3:0] unlock_pattern_ff;
    logic [2:0] requested_mode_ff;
    logic [1:0] input_arrangement_ff;
    logic       device_reset_ff;
    logic       start_calibration_ff;
    logic [7:0] reg_rdata_ff;
    logic [7:0] nxt_rdata;
    logic       clear_regs;
    logic       reset_write;
    logic       key_unlocked;
    logic       hit_status;
    logic       hit_soft_reset;
    logic       hit_calibration;
    logic       hit_unlock_key;
    logic       hit_mode_select;
    logic       hit_input_config;
    logic       wr_unlock_key;
    logic       wr_mode_select;
    logic       wr_input_config;
    logic       wr_calibration;
    logic [3:0] wdata_key;
    logic [2:0] wdata_mode;
    logic [1:0] wdata_config;
    logic       wdata_reset_bit;
    logic       wdata_cal_bit;
    logic [7:0] status_word;
    logic [7:0] key_word;
    logic [7:0] mode_word;
    logic [7:0] config_word;
    logic       two_single_ended;
    logic       remote_ground_sense;
    logic       pseudo_differential;
    smr_mode_if mode_bus ();

    // ----------------------------------------------------------------
    // mode decoder
    // ----------------------------------------------------------------
    // reserved and manual codes both report manual status
    smr_mode_decode u_decode
    (
        .m (mode_bus.dec)
    );

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    // one hit per register; unmapped offsets hit nothing
    assign hit_status       = reg_addr_i == ADDR_MODE_AND_BUS_STATUS;
    assign hit_soft_reset   = reg_addr_i == ADDR_SOFT_RESET_TRIGGER;
    assign hit_calibration  = reg_addr_i == ADDR_CALIBRATION_TRIGGER;
    assign hit_unlock_key   = reg_addr_i == ADDR_RESET_UNLOCK_KEY;
    assign hit_mode_select  = reg_addr_i == ADDR_OPERATING_MODE_SELECT;
    assign hit_input_config = reg_addr_i == ADDR_INPUT_PIN_CONFIG;

    // ----------------------------------------------------------------
    // write data fields
    // ----------------------------------------------------------------
    assign wdata_key       = reg_wdata_i[3:0];
    assign wdata_mode      = reg_wdata_i[2:0];
    assign wdata_config    = reg_wdata_i[1:0];
    assign wdata_reset_bit = reg_wdata_i[SOFT_RESET_BIT_POS];
    assign wdata_cal_bit   = reg_wdata_i[START_CAL_BIT_POS];

    // ----------------------------------------------------------------
    // write strobes
    // ----------------------------------------------------------------
    // device reset clears all but the key; general call clears everything
    assign clear_regs      = gen_call_reset_i | device_reset_ff;
    assign key_unlocked    = unlock_pattern_ff == UNLOCK_PATTERN_VALUE;
    assign reset_write     = reg_wr_i & hit_soft_reset & key_unlocked;
    assign wr_unlock_key   = reg_wr_i & hit_unlock_key;
    assign wr_mode_select  = reg_wr_i & hit_mode_select;
    assign wr_input_config = reg_wr_i & hit_input_config;
    assign wr_calibration  = reg_wr_i & hit_calibration & ~clear_regs;

    // ----------------------------------------------------------------
    // read-back words, reserved bits tied low
    // ----------------------------------------------------------------
    assign status_word = {5'h00, fast_bus_active_i, mode_bus.active_mode};
    assign key_word    = {4'h0, unlock_pattern_ff};
    assign mode_word   = {5'h00, requested_mode_ff};
    assign config_word = {6'h00, input_arrangement_ff};

    // ----------------------------------------------------------------
    // key register
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        // key is kept out of clear_regs, so a device reset leaves it
        if (rst_i)
        begin
            unlock_pattern_ff <= UNLOCK_PATTERN_RST;
        end
        else if (gen_call_reset_i)
        begin
            unlock_pattern_ff <= UNLOCK_PATTERN_RST;
        end
        else if (wr_unlock_key)
        begin
            unlock_pattern_ff <= wdata_key;
        end
    end

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            requested_mode_ff <= REQUESTED_MODE_RST;
        end
        else if (clear_regs)
        begin
            requested_mode_ff <= REQUESTED_MODE_RST;
        end
        else if (wr_mode_select)
        begin
            requested_mode_ff <= wdata_mode;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            input_arrangement_ff <= INPUT_ARRANGEMENT_RST;
        end
        else if (clear_regs)
        begin
            input_arrangement_ff <= INPUT_ARRANGEMENT_RST;
        end
        else if (wr_input_config)
        begin
            input_arrangement_ff <= wdata_config;
        end
    end

    // ----------------------------------------------------------------
    // write-only triggers, one-cycle pulses
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            device_reset_ff <= 1'b0;
        end
        else
        begin
            device_reset_ff <= reset_write & wdata_reset_bit;
        end
    end

    // a calibration write in the cycle of a reset is dropped
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            start_calibration_ff <= 1'b0;
        end
        else
        begin
            start_calibration_ff <= wr_calibration & wdata_cal_bit;
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    // write-only and unmapped offsets read as zero
    always_comb
    begin
        nxt_rdata = READ_ZERO;
        if (hit_status)
        begin
            nxt_rdata = status_word;
        end
        else if (hit_unlock_key)
        begin
            nxt_rdata = key_word;
        end
        else if (hit_mode_select)
        begin
            nxt_rdata = mode_word;
        end
        else if (hit_input_config)
        begin
            nxt_rdata = config_word;
        end
        else if (hit_soft_reset | hit_calibration)
        begin
            nxt_rdata = READ_ZERO;
        end
        else
        begin
            nxt_rdata = READ_ZERO;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            reg_rdata_ff <= READ_ZERO;
        end
        else if (reg_rd_i)
        begin
            // data holds until the next read
            reg_rdata_ff <= nxt_rdata;
        end
    end

    // ----------------------------------------------------------------
    // input arrangement decode
    // ----------------------------------------------------------------
    always_comb
    begin
        two_single_ended    = 1'b0;
        remote_ground_sense = 1'b0;
        pseudo_differential = 1'b0;
        case (input_arrangement_ff)
            CFG_TWO_SINGLE, CFG_TWO_SINGLE_B:
            begin
                two_single_ended = 1'b1;
            end
            CFG_REMOTE_GND:
            begin
                remote_ground_sense = 1'b1;
            end
            CFG_PSEUDO_DIFF:
            begin
                pseudo_differential = 1'b1;
            end
            default:
            begin
                two_single_ended = 1'b1;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign mode_bus.requested_mode = requested_mode_ff;
    assign reg_rdata_o             = reg_rdata_ff;
    assign device_reset_o          = device_reset_ff;
    assign start_calibration_o     = start_calibration_ff;
    assign requested_mode_o        = requested_mode_ff;
    assign active_mode_o           = mode_bus.active_mode;
    assign manual_ch0_only_o       = mode_bus.manual_ch0_only;
    assign auto_sequence_o         = mode_bus.auto_sequence;
    assign mode_reserved_o         = mode_bus.mode_reserved;
    assign input_arrangement_o     = input_arrangement_ff;
    assign two_single_ended_o      = two_single_ended;
    assign remote_ground_sense_o   = remote_ground_sense;
    assign pseudo_differential_o   = pseudo_differential;

endmodule : smr_regs

/* File: test/smr_host_model.sv */
// host side register access model
`timescale 1ns/1ps
module smr_host_model
(
    input  wire logic       ref_clk_i,
    input  wire logic [7:0] reg_rdata_i,
    output logic            reg_wr_o,
    output logic            reg_rd_o,
    output logic [7:0]      reg_addr_o,
    output logic [7:0]      reg_wdata_o
);
    initial
    begin
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
        reg_addr_o  = 8'hFF;
        reg_wdata_o = 8'hFF;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk_i);
        reg_wr_o    = 1'b1;
        reg_addr_o  = a;
        reg_wdata_o = d;
        @(negedge ref_clk_i);
        reg_wr_o    = 1'b0;
        reg_addr_o  = ~a;
        reg_wdata_o = ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge ref_clk_i);
        reg_rd_o   = 1'b1;
        reg_addr_o = a;
        @(negedge ref_clk_i);
        reg_rd_o   = 1'b0;
        reg_addr_o = ~a;
        d          = reg_rdata_i;
    endtask : rd
endmodule : smr_host_model

/* File: test/smr_regs_properties.sv */
// port checker for the mode and reset register bank
`timescale 1ns/1ps
module smr_regs_properties
    import smr_pkg::*;
(
    input wire logic       ref_clk_i,
    input wire logic       rst_i,
    input wire logic       gen_call_reset_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       fast_bus_active_i,
    input wire logic       device_reset_o,
    input wire logic       start_calibration_o,
    input wire logic [2:0] requested_mode_o,
    input wire logic [1:0] active_mode_o,
    input wire logic       manual_ch0_only_o,
    input wire logic       auto_sequence_o,
    input wire logic       mode_reserved_o,
    input wire logic [1:0] input_arrangement_o,
    input wire logic       two_single_ended_o,
    input wire logic       remote_ground_sense_o,
    input wire logic       pseudo_differential_o
);
    logic [3:0] key_ff;
    logic       rst_wr;
    logic       cal_wr;
    logic       mode_wr;
    assign rst_wr  = reg_wr_i && reg_addr_i == ADDR_SOFT_RESET_TRIGGER && reg_wdata_i[0];
    assign cal_wr  = reg_wr_i && reg_addr_i == ADDR_CALIBRATION_TRIGGER && reg_wdata_i[0];
    assign mode_wr = reg_wr_i && reg_addr_i == ADDR_OPERATING_MODE_SELECT;

    // shadow of the unlock pattern
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
            key_ff <= 4'h0;
        else if (gen_call_reset_i)
            key_ff <= 4'h0;
        else if (reg_wr_i && reg_addr_i == ADDR_RESET_UNLOCK_KEY)
            key_ff <= reg_wdata_i[3:0];
    end

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    a_reset_needs_key: assert property (
        device_reset_o |-> $past(rst_wr && key_ff == UNLOCK_PATTERN_VALUE)) else $error("reset pulse while locked");
    a_reset_fires: assert property (
        rst_wr && key_ff == UNLOCK_PATTERN_VALUE && !gen_call_reset_i |=> device_reset_o)
        else $error("unlocked reset write gave no pulse");
    a_reset_clears: assert property (
        device_reset_o |=> requested_mode_o == 3'h0 && input_arrangement_o == 2'h0) else $error("reset kept config");
    a_cal_fires: assert property (
        cal_wr && !gen_call_reset_i && !device_reset_o |=> start_calibration_o) else $error("no calibration pulse");
    a_cal_cause: assert property (
        start_calibration_o |-> $past(cal_wr)) else $error("calibration pulse without write");
    a_mode_write: assert property (
        mode_wr && !gen_call_reset_i && !device_reset_o |=> requested_mode_o == $past(reg_wdata_i[2:0]))
        else $error("mode field not stored");
    a_mode_decode: assert property (
        active_mode_o == (requested_mode_o == 3'h6 ? 2'h2 : requested_mode_o == 3'h7 ? 2'h3 : 2'h0)
        && mode_reserved_o == (requested_mode_o[2:1] == 2'h1)) else $error("mode decode wrong");
    a_mode_flags: assert property (
        manual_ch0_only_o == (requested_mode_o[2:1] == 2'h0) && auto_sequence_o == requested_mode_o[2])
        else $error("mode flags wrong");
    a_key_read: assert property (
        reg_rd_i && reg_addr_i == ADDR_RESET_UNLOCK_KEY |=> reg_rdata_o == {4'h0, $past(key_ff)})
        else $error("key read wrong");
    a_status_read: assert property (
        reg_rd_i && reg_addr_i == ADDR_MODE_AND_BUS_STATUS
        |=> reg_rdata_o == {5'h00, $past(fast_bus_active_i), $past(active_mode_o)}) else $error("status read wrong");
    a_cfg_decode: assert property (
        pseudo_differential_o == (input_arrangement_o == 2'h2) && remote_ground_sense_o == (input_arrangement_o == 2'h1)
        && two_single_ended_o == (input_arrangement_o[1] == input_arrangement_o[0])) else $error("input decode wrong");
    a_gcall_clears: assert property (
        gen_call_reset_i |=> requested_mode_o == 3'h0 && input_arrangement_o == 2'h0) else $error("general reset kept config");
endmodule : smr_regs_properties

bind smr_regs smr_regs_properties i_prop (.*);

/* File: test/smr_regs_tb_top.sv */
// self-checking bench for the mode and reset register bank
`timescale 1ns/1ps
module smr_regs_tb_top
    import smr_pkg::*;
;
    typedef struct packed {
        logic [7:0] wa;
        logic [7:0] wd;
        logic [7:0] ra;
        logic [7:0] ex;
        logic       fb;
        logic [7:0] dx;
        logic [7:0] sx;
    } smr_row_type;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic gcr = 1'b0;
    logic fb = 1'b0;
    logic wr, rd;
    logic [7:0] addr, wdata, rdata, d;
    int n_fail = 0, checks = 0, cyc = 0, n_rst = 0, n_cal = 0;
    // dx = {active mode, manual ch0, auto seq, reserved, two single, remote gnd, pseudo diff}
    // sx = {000, mode select, input arrangement}
    smr_row_type rows [18] = '{
        '{8'h1C, 8'hFF, 8'h1C, 8'h07, 1'b0, 8'hD4, 8'h1C}, '{8'h1C, 8'h06, 8'h00, 8'h02, 1'b0, 8'h94, 8'h18},
        '{8'h1C, 8'h07, 8'h00, 8'h07, 1'b1, 8'hD4, 8'h1C}, '{8'h1C, 8'h03, 8'h00, 8'h00, 1'b0, 8'h0C, 8'h0C},
        '{8'h1C, 8'h04, 8'h1C, 8'h04, 1'b0, 8'h14, 8'h10}, '{8'h24, 8'hFF, 8'h24, 8'h03, 1'b0, 8'h14, 8'h13},
        '{8'h24, 8'h02, 8'h24, 8'h02, 1'b0, 8'h11, 8'h12}, '{8'h30, 8'hFF, 8'h30, 8'h00, 1'b0, 8'h11, 8'h12},
        '{8'h17, 8'h0A, 8'h17, 8'h0A, 1'b0, 8'h11, 8'h12}, '{8'h15, 8'h01, 8'h15, 8'h00, 1'b0, 8'h11, 8'h12},
        '{8'h14, 8'h01, 8'h14, 8'h00, 1'b0, 8'h24, 8'h00}, '{8'h00, 8'hFF, 8'h00, 8'h00, 1'b0, 8'h24, 8'h00},
        '{8'h15, 8'h01, 8'h24, 8'h00, 1'b0, 8'h24, 8'h00}, '{8'h24, 8'h01, 8'h17, 8'h0A, 1'b0, 8'h22, 8'h01},
        '{8'h17, 8'h00, 8'h17, 8'h00, 1'b0, 8'h22, 8'h01}, '{8'h1C, 8'h05, 8'h1C, 8'h05, 1'b0, 8'h12, 8'h15},
        '{8'h14, 8'h01, 8'h1C, 8'h05, 1'b0, 8'h12, 8'h15}, '{8'h1C, 8'h01, 8'h1C, 8'h01, 1'b0, 8'h22, 8'h05}};
    logic soft_reset_bit, cal, man, aseq, mres, two_se, rgs, pdiff;
    logic [2:0] req_mode;
    logic [1:0] act_mode, in_arr;

    smr_host_model i_host (.ref_clk_i(ref_clk_i), .reg_rdata_i(rdata), .reg_wr_o(wr), .reg_rd_o(rd),
        .reg_addr_o(addr), .reg_wdata_o(wdata));
    smr_regs i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .gen_call_reset_i(gcr), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .fast_bus_active_i(fb),
        .device_reset_o(soft_reset_bit), .start_calibration_o(cal), .requested_mode_o(req_mode), .active_mode_o(act_mode),
        .manual_ch0_only_o(man), .auto_sequence_o(aseq), .mode_reserved_o(mres), .input_arrangement_o(in_arr),
        .two_single_ended_o(two_se), .remote_ground_sense_o(rgs), .pseudo_differential_o(pdiff));

    always #5 ref_clk_i = ~ref_clk_i;

    always @(posedge ref_clk_i)
    begin
        cyc++;
        n_rst += (soft_reset_bit === 1'b1);
        n_cal += (cal === 1'b1);
        if (cyc == 1000)
        begin
            n_fail++;
            tally_and_finish();
        end
    end

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic tally_and_finish();
        if (n_fail == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        repeat (15) @(negedge ref_clk_i);
        chk("rdata in reset", rdata, 8'h00);
        chk("pulses in reset", {7'h00, soft_reset_bit | cal}, 8'h00);
        @(negedge ref_clk_i);
        rst_i = 1'b0;
        foreach (rows[i])
        begin
            fb = rows[i].fb;
            i_host.wr(rows[i].wa, rows[i].wd);
            i_host.rd(rows[i].ra, d);
            chk("row read", d, rows[i].ex);
            chk("decode flags", {act_mode, man, aseq, mres, two_se, rgs, pdiff}, rows[i].dx);
            chk("config fields", {3'h0, req_mode, in_arr}, rows[i].sx);
        end
        chk("reset pulses", 8'(n_rst), 8'h01);
        chk("cal pulses", 8'(n_cal), 8'h02);
        i_host.wr(8'h17, 8'h0A);
        i_host.wr(8'h24, 8'h01);
        @(negedge ref_clk_i);
        gcr = 1'b1;
        @(negedge ref_clk_i);
        gcr = 1'b0;
        i_host.rd(8'h17, d);
        chk("key after general reset", d, 8'h00);
        i_host.rd(8'h1C, d);
        chk("mode after general reset", d, 8'h00);
        i_host.rd(8'h24, d);
        chk("config after general reset", d, 8'h00);
        tally_and_finish();
    end
endmodule : smr_regs_tb_top
